// ===== logic/pdpsm_power_state_manager.sv
// Summary of operation
// - core clock 12 MHz active, 4-6 MHz idle, 100 kHz sleep
// - 24 MHz oscillator on in active and idle, off in sleep
// - 100 kHz oscillator enabled in every state
// - type-c attach/detach detection works in every state
// - pd messaging only while active
// - i2c served in active and idle, not in sleep
// - spi usable only while active
// - attach or detach in idle or sleep wakes to active
// - pd message wakes idle and is discarded; ignored in sleep
// - i2c traffic addressed to us wakes from idle or sleep
// - boot config bundle arrives over i2c or spi
// - i2c host interface configures and controls the device
// - internal 3v3 rail from bus power forces sink-only role
`timescale 1ns/10ps
module pdpsm_power_state_manager #(
	parameter int unsigned SETTLE = pdpsm_pkg::SETTLE_CYC
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   srst,
	// pins from outside the domain
	input  wire logic                   attachDetPin,
	input  wire logic                   internal3v3FromBus,
	// events from same-clock logic
	input  wire pdpsm_pkg::pdpsm_evt_t  evtIn,
	input  wire logic                   pdMsgValid,
	input  wire logic                   bootLoadDone,
	input  wire logic                   bootLoadSpi,
	// outputs
	output logic                        pdMsgAccept,
	output pdpsm_pkg::pdpsm_state_t     powerState,
	output pdpsm_pkg::pdpsm_clk_t       clkCfg,
	output pdpsm_pkg::pdpsm_feat_t      featEn,
	output pdpsm_pkg::pdpsm_boot_t      bootStat,
	output logic                        attachEvt
);
	import pdpsm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [1:0]     attSync;
		logic [1:0]     busSync;
		logic           attPrev;
		pdpsm_state_t   state;
		logic [7:0]     settle;
		logic           dropPd;
		pdpsm_clk_t     clk;
		pdpsm_feat_t    feat;
		pdpsm_boot_t    boot;
		logic           pdAcc;
		logic           attEvt;
	} pdpsm_regs_t;

	pdpsm_regs_t r_q;
	pdpsm_regs_t r_d;

	// clock settings for a given state
	function automatic pdpsm_clk_t clkFor(input pdpsm_state_t s);
		pdpsm_clk_t c;
		c.osc100kEn = 1'b1;
		case (s)
			PS_ACTIVE: begin
				c.coreClkSel = CSEL_12M;
				c.coreClkKhz = KHZ_ACT;
				c.osc24mEn   = 1'b1;
			end
			PS_IDLE: begin
				c.coreClkSel = CSEL_MID;
				c.coreClkKhz = KHZ_IDLE;
				c.osc24mEn   = 1'b1;
			end
			default: begin
				c.coreClkSel = CSEL_100K;
				c.coreClkKhz = KHZ_SLEEP;
				c.osc24mEn   = 1'b0;
			end
		endcase
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic attChange;
	logic wake;
	logic settled;

	always_comb begin
		r_d = r_q;
		// second flop only feeds logic; first flop only feeds second
		r_d.attSync = {r_q.attSync[0], attachDetPin};
		r_d.busSync = {r_q.busSync[0], internal3v3FromBus};
		r_d.attPrev = r_q.attSync[1];
		attChange   = r_q.attSync[1] ^ r_q.attPrev;
		r_d.attEvt  = attChange | evtIn.attachChg;
		r_d.pdAcc   = 1'b0;
		settled     = (r_q.settle == 8'h00);
		wake        = 1'b0;

		// boot bundle status, latched once loaded
		if (bootLoadDone && !r_q.boot.bootDone) begin
			r_d.boot.bootDone   = 1'b1;
			r_d.boot.loadViaSpi = bootLoadSpi;
		end

		case (r_q.state)
			PS_ACTIVE: begin
				// an attach change or i2c address match in the same cycle beats a power-down request; a pd message does not
				if (attChange || evtIn.attachChg || evtIn.i2cAddr) begin
					r_d.state = PS_ACTIVE;
				end else if (evtIn.reqSleep) begin
					r_d.state = PS_SLEEP;
				end else if (evtIn.reqIdle) begin
					r_d.state = PS_IDLE;
				end
			end
			PS_IDLE: begin
				if (attChange || evtIn.attachChg) begin
					wake = 1'b1;
				end else if (evtIn.i2cAddr) begin
					wake = 1'b1;
				end else if (evtIn.pdMsg || pdMsgValid) begin
					wake       = 1'b1;
					r_d.dropPd = 1'b1;
				end else if (evtIn.reqSleep) begin
					r_d.state = PS_SLEEP;
				end
			end
			default: begin
				// pd traffic is no wake source here
				if (attChange || evtIn.attachChg) begin
					wake = 1'b1;
				end else if (evtIn.i2cAddr) begin
					wake = 1'b1;
				end
			end
		endcase

		if (wake) begin
			r_d.state  = PS_ACTIVE;
			r_d.settle = 8'(SETTLE);
		end else if (!settled) begin
			r_d.settle = r_q.settle - 8'h01;
		end

		r_d.clk = clkFor(r_d.state);

		// features follow the next state; active-only ones wait
		// for the clock switch to settle
		r_d.feat.typecDetEn = 1'b1;
		r_d.feat.pdCommEn = (r_d.state == PS_ACTIVE) && settled
			&& !wake;
		r_d.feat.spiEn = (r_d.state == PS_ACTIVE) && settled
			&& !wake;
		r_d.feat.i2cEn = (r_d.state != PS_SLEEP);
		r_d.feat.sinkOnly = r_q.busSync[1];

		// first message after pd wake is thrown away
		if (pdMsgValid && r_q.feat.pdCommEn) begin
			if (r_q.dropPd) begin
				r_d.dropPd = 1'b0;
			end else begin
				r_d.pdAcc = 1'b1;
			end
		end else if (r_q.state == PS_IDLE && !wake) begin
			r_d.dropPd = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (srst) begin
			r_q         <= '0;
			r_q.state   <= PS_ACTIVE;
			r_q.clk     <= clkFor(PS_ACTIVE);
			r_q.feat    <= 5'h1c;
		end else begin
			r_q <= r_d;
		end
	end

	assign pdMsgAccept = r_q.pdAcc;
	assign powerState  = r_q.state;
	assign clkCfg      = r_q.clk;
	assign featEn      = r_q.feat;
	assign bootStat    = r_q.boot;
	assign attachEvt   = r_q.attEvt;

endmodule

// ===== logic/pdpsm_pkg.sv
package pdpsm_pkg;

	// power states
	typedef enum logic [1:0] {
		PS_ACTIVE,
		PS_IDLE,
		PS_SLEEP
	} pdpsm_state_t;

	// clk frequency in Hz, then core clock frequencies in kHz per state
	localparam int unsigned CLK_HZ         = 10000000;
	localparam int unsigned CORE_KHZ_ACT   = 12000;
	localparam int unsigned CORE_KHZ_IDLE  = 5000;
	localparam int unsigned CORE_KHZ_IDLMIN = 4000;
	localparam int unsigned CORE_KHZ_IDLMAX = 6000;
	localparam int unsigned CORE_KHZ_SLEEP = 100;

	// core clock select codes
	localparam logic [1:0] CSEL_12M  = 2'h0;
	localparam logic [1:0] CSEL_MID  = 2'h1;
	localparam logic [1:0] CSEL_100K = 2'h2;

	// clock/oscillator settings
	typedef struct packed {
		logic [1:0]  coreClkSel;
		logic [15:0] coreClkKhz;
		logic        osc24mEn;
		logic        osc100kEn;
	} pdpsm_clk_t;

	// feature enables
	typedef struct packed {
		logic typecDetEn;
		logic pdCommEn;
		logic i2cEn;
		logic spiEn;
		logic sinkOnly;
	} pdpsm_feat_t;

	// wake and sleep requests
	typedef struct packed {
		logic attachChg;
		logic pdMsg;
		logic i2cAddr;
		logic reqIdle;
		logic reqSleep;
	} pdpsm_evt_t;

	// boot configuration load status
	typedef struct packed {
		logic bootDone;
		logic loadViaSpi;
	} pdpsm_boot_t;

	localparam logic [15:0] KHZ_ACT   = 16'h2ee0;
	localparam logic [15:0] KHZ_IDLE  = 16'h1388;
	localparam logic [15:0] KHZ_SLEEP = 16'h0064;

	// cycles the clock switch needs to settle before features resume
	localparam int unsigned SETTLE_NS  = 1000;
	localparam int unsigned SETTLE_CYC =
		(SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;

endpackage

// ===== dv/pdpsm_monitor.sv
`timescale 1ns/10ps
module pdpsm_monitor (
	// clock and reset
	input wire logic                   clk,
	input wire logic                   srst,
	// watched ports
	input wire pdpsm_pkg::pdpsm_evt_t  evtIn,
	input wire logic                   pdMsgValid,
	input wire logic                   pdMsgAccept,
	input wire pdpsm_pkg::pdpsm_state_t powerState,
	input wire pdpsm_pkg::pdpsm_clk_t  clkCfg,
	input wire pdpsm_pkg::pdpsm_feat_t featEn
);
	import pdpsm_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////
	sequence pdWake;
		powerState == PS_IDLE && pdMsgValid && !evtIn.attachChg
			&& !evtIn.i2cAddr;
	endsequence
	chk_core_khz: assert property (clkCfg.coreClkKhz ==
		(powerState == PS_ACTIVE ? KHZ_ACT :
		powerState == PS_IDLE ? KHZ_IDLE : KHZ_SLEEP))
		else $error("core clock wrong");
	chk_fast_osc: assert property (
		clkCfg.osc24mEn == (powerState != PS_SLEEP))
		else $error("fast osc wrong");
	chk_slow_osc: assert property (clkCfg.osc100kEn)
		else $error("slow osc off");
	chk_typec_det: assert property (featEn.typecDetEn)
		else $error("detect off");
	chk_pd_active: assert property (
		featEn.pdCommEn |-> powerState == PS_ACTIVE)
		else $error("pd outside active");
	chk_i2c_sleep: assert property (
		featEn.i2cEn |-> powerState != PS_SLEEP)
		else $error("i2c in sleep");
	chk_spi_active: assert property (
		featEn.spiEn |-> powerState == PS_ACTIVE)
		else $error("spi outside active");
	chk_attach_wake: assert property (
		evtIn.attachChg |=> powerState == PS_ACTIVE)
		else $error("no attach wake");
	chk_pd_drop: assert property (
		pdWake |=> powerState == PS_ACTIVE && !pdMsgAccept)
		else $error("pd wake wrong");
	chk_i2c_wake: assert property (
		evtIn.i2cAddr |=> powerState == PS_ACTIVE)
		else $error("no i2c wake");
	chk_clk_first: assert property (featEn.pdCommEn |->
		clkCfg.osc24mEn && clkCfg.coreClkSel == CSEL_12M)
		else $error("pd before clock");
endmodule

// ===== dv/pdpsm_host_model.sv
`timescale 1ns/10ps
module pdpsm_host_model (
	// bench requests
	input wire logic                  clk,
	input wire pdpsm_pkg::pdpsm_evt_t req,
	input wire logic                  bootReq,
	input wire logic                  spiSel,
	// toward the device
	output pdpsm_pkg::pdpsm_evt_t     evt,
	output logic                      bootDone,
	output logic                      viaSpi
);
	import pdpsm_pkg::*;
	// requests are delayed one cycle; pulse length is whatever the bench drives
	always_ff @(posedge clk) begin
		evt      <= req;
		bootDone <= bootReq;
		viaSpi   <= spiSel;
	end
endmodule

// ===== dv/pd_controller_power_state_manager_bench.sv
`timescale 1ns/10ps
module pd_controller_power_state_manager_bench;
	import pdpsm_pkg::*;
	logic clk = 1'b0, srst = 1'b1, pin = 1'b0, fromBus = 1'b0;
	logic pdV = 1'b0, bootReq = 1'b0, bDone, bSpi, acc, aEvt;
	pdpsm_evt_t req = '0, evt;
	pdpsm_state_t st;
	pdpsm_clk_t ck;
	pdpsm_feat_t fe;
	pdpsm_boot_t bs;
	int error_cnt = 0, samples_checked = 0, accCnt = 0, attCnt = 0;
	////////////////////////////////////////////////////////////////
	pdpsm_host_model pdpsm_host_model_inst (.clk(clk), .req(req),
		.bootReq(bootReq), .spiSel(1'b1), .evt(evt),
		.bootDone(bDone), .viaSpi(bSpi));
	// short settle keeps the run brief
	pdpsm_power_state_manager #(.SETTLE(2)) pdpsm_power_state_manager_inst (
		.clk(clk), .srst(srst), .attachDetPin(pin),
		.internal3v3FromBus(fromBus), .evtIn(evt), .pdMsgValid(pdV),
		.bootLoadDone(bDone), .bootLoadSpi(bSpi), .pdMsgAccept(acc),
		.powerState(st), .clkCfg(ck), .featEn(fe), .bootStat(bs),
		.attachEvt(aEvt));
	initial forever #50 clk = ~clk;
	always @(posedge clk) if (acc === 1'b1) accCnt++;
	always @(posedge clk) if (aEvt === 1'b1) attCnt++;
	////////////////////////////////////////////////////////////////
	// wide enough for state plus a 16-bit field without truncation
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic ev(input pdpsm_evt_t e);
		@(posedge clk) req <= e;
		@(posedge clk) req <= '0;
		w(3);
	endtask
	task automatic pd;
		@(posedge clk) pdV <= 1'b1;
		@(posedge clk) pdV <= 1'b0;
		w(2);
	endtask
	task automatic results;
		if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_idle;
		ev(5'h02);
		cmp(ck.coreClkKhz, KHZ_IDLE);
		cmp({ck.osc24mEn, fe.pdCommEn, fe.i2cEn, fe.spiEn}, 4'ha);
		ev(5'h04);
		cmp(st, PS_ACTIVE);
		w(4);
		cmp({ck.coreClkKhz, fe.pdCommEn, fe.spiEn}, {KHZ_ACT, 2'h3});
	endtask
	task automatic t_sleep;
		ev(5'h01);
		cmp(ck.coreClkKhz, KHZ_SLEEP);
		cmp({ck.osc24mEn, ck.osc100kEn, fe.typecDetEn, fe.i2cEn}, 4'h6);
		pd();
		cmp(st, PS_SLEEP);
		ev(5'h10);
		cmp(st, PS_ACTIVE);
	endtask
	task automatic t_pdwake;
		ev(5'h02);
		accCnt = 0;
		pd();
		cmp({st, 16'(accCnt)}, {PS_ACTIVE, 16'h0});
		w(4);
		pd();
		pd();
		cmp(accCnt > 0, 1'b1);
	endtask
	task automatic t_misc;
		ev(5'h02);
		attCnt = 0;
		@(posedge clk) pin <= 1'b1;
		w(6);
		cmp(st, PS_ACTIVE);
		cmp(attCnt, 32'h1);
		@(posedge clk) fromBus <= 1'b1;
		w(5);
		cmp(fe.sinkOnly, 1'b1);
		@(posedge clk) bootReq <= 1'b1;
		@(posedge clk) bootReq <= 1'b0;
		w(3);
		cmp(bs, 2'h3);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		w(2);
		t_idle();
		t_sleep();
		t_pdwake();
		t_misc();
		results();
	end
	// whole sequence is well under 200 cycles
	initial begin
		#100000;
		error_cnt++;
		results();
	end
endmodule
bind pdpsm_power_state_manager pdpsm_monitor pdpsm_monitor_inst (
	.clk(clk), .srst(srst), .evtIn(evtIn), .pdMsgValid(pdMsgValid),
	.pdMsgAccept(pdMsgAccept), .powerState(powerState),
	.clkCfg(clkCfg), .featEn(featEn));
